// [logic/acs_filter.sv]
// Consecutive out-of-range sample filter for one channel.
// Assumes samples arrive on sys_clk as one-cycle strobes.
`timescale 1ns/1ps
`include "acs_params.svh"
module acs_filter
  import acs_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  acs_filter_if.filt fi
);
  logic [`ACS_CNT_W-1:0] run;
  acs_run_type state;
  wire [`ACS_CNT_W-1:0] next_run = run + `ACS_CNT_W'(1);
  wire hit = fi.sample_valid && fi.out_of_range && (next_run >= fi.need);

  // ****************************************
  // Run counter, cleared by an in-range sample
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      run <= '0;
      state <= ACS_RUN_IDLE;
    end else if (fi.sample_valid) begin
      if (!fi.out_of_range) begin
        run <= '0;
        state <= ACS_RUN_IDLE;
      end else if (hit) begin
        state <= ACS_RUN_HIT;
      end else begin
        run <= next_run;
      end
    end
  end

  // Alarm pulse on the sample that completes the run
  assign fi.alarm = hit && (state == ACS_RUN_IDLE);

  AST_RESTART: assert property (@(posedge sys_clk) disable iff (!rst_n)
    fi.sample_valid && !fi.out_of_range |=> run == '0)
    else $error("run counter not restarted");
endmodule

// [logic/acs_filter_if.sv]
// Carrier between the register top and a filter counter.
// Assumes the top drives configuration, filter drives alarm.
`timescale 1ns/1ps
`include "acs_params.svh"
interface acs_filter_if;
  logic sample_valid;
  logic out_of_range;
  logic [`ACS_CNT_W-1:0] need;
  logic alarm;
  modport ctrl (output sample_valid, output out_of_range, output need, input alarm);
  modport filt (input sample_valid, input out_of_range, input need, output alarm);
endinterface

// [logic/acs_params.svh]
// Constants for the alarm and configuration register block.
// Assumes inclusion by bare name from logic/ files.
`ifndef ACS_PARAMS_SVH
`define ACS_PARAMS_SVH

// ****************************************
// Register addresses
// ****************************************
`define ACS_ADDR_CFG1 7'h4D
`define ACS_ADDR_STATUS 7'h40

// ****************************************
// Field layout and reset values
// ****************************************
`define ACS_CFG1_RESET 16'h0070
`define ACS_CFG1_MASK 16'h03F8
`define ACS_RATE_HI 9
`define ACS_RATE_LO 8
`define ACS_CHF_HI 7
`define ACS_CHF_LO 5
`define ACS_TPF_HI 4
`define ACS_TPF_LO 3
`define ACS_GLOBAL_ALARM_FLAG_BIT 6
`define ACS_STATUS_IND_MASK 16'hFF80

// ****************************************
// Filter and rate figures
// ****************************************
`define ACS_NUM_CH 4
`define ACS_CNT_W 9
`define ACS_RATE_W 3
`define ACS_CH_CODE_FOUR 3'h1
`define ACS_CH_CODE_MAX 3'h7
`define ACS_RATE_MAX 3'h3
`define ACS_STATUS_RSVD_MASK 16'h003F

// ****************************************
// Consecutive samples needed per filter code
// ****************************************
`define ACS_CH_NEED_C0 9'h001
`define ACS_CH_NEED_C1 9'h004
`define ACS_CH_NEED_C2 9'h008
`define ACS_CH_NEED_C3 9'h010
`define ACS_CH_NEED_C4 9'h020
`define ACS_CH_NEED_C5 9'h040
`define ACS_CH_NEED_C6 9'h080
`define ACS_CH_NEED_C7 9'h100
`define ACS_TP_NEED_C0 9'h001
`define ACS_TP_NEED_C1 9'h002
`define ACS_TP_NEED_C2 9'h004
`define ACS_TP_NEED_C3 9'h008

`endif

// [logic/acs_pkg.sv]
// Types for the alarm and configuration register block.
// Assumes acs_params.svh alongside.
package acs_pkg;
  typedef enum logic [1:0] {ACS_RATE_FULL, ACS_RATE_HALF, ACS_RATE_QUARTER, ACS_RATE_EIGHTH}
    acs_rate_type;
  typedef enum logic [0:0] {ACS_RUN_IDLE, ACS_RUN_HIT} acs_run_type;
endpackage

// [logic/acs_regs.sv]
// Status and configuration register 1 with alarm filters.
// Assumes a serial host front end giving address, write and read strobes.
//
// Overview of operation
// - Status bit 6 is the OR of individual alarm bits 15:7 and the sticky global alarm flag.
// - Global alarm sets on any alarm and holds until status read.
// - Reading the status register clears the global alarm bit unless an alarm is present in that cycle.
// - Reserved bits ignore writes and read as zero.
// - Configuration register 1 is read/write at 4Dh, reset 0070h.
// - Bits 9:8 hold the conversion rate select, reset zero.
// - Rate codes give full, half, quarter, eighth of 500 kSPS.
// - Bits 7:5 hold input filter count, reset 011.
// - Bits 4:3 hold temperature filter count, reset 10.
// - Input codes need 1,4,8,16,32,64,128,256 consecutive bad samples.
// - Temperature codes need 1,2,4,8 consecutive bad samples.
`timescale 1ns/1ps
`include "acs_params.svh"
module acs_regs
  import acs_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [6:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  input wire logic [15:0] alarm_bits,
  input wire logic [`ACS_NUM_CH-1:0] ch_sample_valid,
  input wire logic [`ACS_NUM_CH-1:0] ch_out_of_range,
  input wire logic temp_sample_valid,
  input wire logic temp_out_of_range,
  output logic [`ACS_NUM_CH-1:0] ch_alarm,
  output logic temp_alarm,
  output logic [`ACS_RATE_W-1:0] rate_shift,
  output logic [1:0] conversion_rate_select,
  output logic [2:0] input_alarm_filter_count,
  output logic [1:0] temp_alarm_filter_count
);
  logic [15:0] cfg1;
  logic global_alarm_flag;

  // ****************************************
  // Address decode
  // ****************************************
  wire hit_cfg = reg_addr == `ACS_ADDR_CFG1;
  wire hit_sts = reg_addr == `ACS_ADDR_STATUS;
  wire wr_cfg = reg_wr && hit_cfg;
  wire rd_sts = reg_rd && hit_sts;
  wire any_alarm = |(alarm_bits & `ACS_STATUS_IND_MASK);

  // Field views of configuration register 1
  assign conversion_rate_select = cfg1[`ACS_RATE_HI:`ACS_RATE_LO];
  assign input_alarm_filter_count = cfg1[`ACS_CHF_HI:`ACS_CHF_LO];
  assign temp_alarm_filter_count = cfg1[`ACS_TPF_HI:`ACS_TPF_LO];

  // Rate divider as a power-of-two shift: 1, 2, 4, 8
  assign rate_shift = {1'b0, conversion_rate_select};

  // Required run lengths from the filter codes
  // Shift amount widened so code 111 gives 256, not a wrap to 1
  wire [`ACS_CNT_W-1:0] ch_need = (input_alarm_filter_count == 3'h0) ? `ACS_CNT_W'(1) :
    (`ACS_CNT_W'(1) << ({1'b0, input_alarm_filter_count} + 4'h1));
  wire [`ACS_CNT_W-1:0] tp_need = `ACS_CNT_W'(1) << temp_alarm_filter_count;

  // ****************************************
  // Configuration register 1
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cfg1 <= `ACS_CFG1_RESET;
    end else if (wr_cfg) begin
      cfg1 <= reg_wdata & `ACS_CFG1_MASK;
    end
  end

  // ****************************************
  // Global alarm flag, set wins over read clear
  // ****************************************
  wire next_flag = any_alarm ? 1'b1 : (rd_sts ? 1'b0 : global_alarm_flag);
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      global_alarm_flag <= 1'b0;
    end else begin
      global_alarm_flag <= next_flag;
    end
  end

  // ****************************************
  // Read data, registered
  // ****************************************
  wire [15:0] sts_word = (alarm_bits & `ACS_STATUS_IND_MASK)
    | (16'(global_alarm_flag | any_alarm) << `ACS_GLOBAL_ALARM_FLAG_BIT);
  wire [15:0] rd_word = hit_cfg ? cfg1 : (hit_sts ? sts_word : 16'h0000);
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata <= rd_word;
    end
  end

  // ****************************************
  // Filter counters per channel and temperature
  // ****************************************
  acs_filter_if fif[`ACS_NUM_CH+1] ();
  genvar g;
  generate
    for (g = 0; g <= `ACS_NUM_CH; g++) begin : g_flt
      if (g < `ACS_NUM_CH) begin : g_ch
        assign fif[g].sample_valid = ch_sample_valid[g];
        assign fif[g].out_of_range = ch_out_of_range[g];
        assign fif[g].need = ch_need;
        assign ch_alarm[g] = fif[g].alarm;
      end else begin : g_tp
        assign fif[g].sample_valid = temp_sample_valid;
        assign fif[g].out_of_range = temp_out_of_range;
        assign fif[g].need = tp_need;
        assign temp_alarm = fif[g].alarm;
      end
      acs_filter u_flt (.sys_clk(sys_clk), .rst_n(rst_n), .fi(fif[g]));
    end
  endgenerate

  // ****************************************
  // Register checks
  // ****************************************
  // Reserved bits, config storage and read-back
  AST_RSVD: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (cfg1 & ~`ACS_CFG1_MASK) == 16'h0000)
    else $error("reserved config bit set");
  AST_STS_RSVD: assert property (@(posedge sys_clk) disable iff (!rst_n)
    reg_rd && hit_sts |=> (reg_rdata & `ACS_STATUS_RSVD_MASK) == 16'h0000)
    else $error("reserved status bit nonzero");
  AST_CFG_WR: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wr_cfg |=> cfg1 == ($past(reg_wdata) & `ACS_CFG1_MASK))
    else $error("config write not stored");
  AST_CFG_KEEP: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !wr_cfg |=> $stable(cfg1))
    else $error("config changed without a write");
  AST_CFG_RD: assert property (@(posedge sys_clk) disable iff (!rst_n)
    reg_rd && hit_cfg |=> reg_rdata == $past(cfg1))
    else $error("config read data wrong");
  AST_RESET_VAL: assert property (@(posedge sys_clk)
    !rst_n |=> cfg1 == `ACS_CFG1_RESET)
    else $error("config reset value wrong");
  AST_RATE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rate_shift[1:0] == cfg1[`ACS_RATE_HI:`ACS_RATE_LO])
    else $error("rate select not applied");
  AST_RATE_RANGE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rate_shift <= `ACS_RATE_MAX)
    else $error("rate divider beyond one eighth");

  // ****************************************
  // Global alarm flag checks
  // ****************************************
  // Sticky flag, cleared by a read unless an alarm is present
  AST_GLOBAL_ALARM_FLAG_OR: assert property (@(posedge sys_clk) disable iff (!rst_n)
    reg_rd && hit_sts && any_alarm |=> reg_rdata[`ACS_GLOBAL_ALARM_FLAG_BIT])
    else $error("global bit missing with alarm bit set");
  AST_GLOBAL_ALARM_FLAG_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_n)
    any_alarm |=> global_alarm_flag)
    else $error("global flag not set by alarm");
  AST_GLOBAL_ALARM_FLAG_STICK: assert property (@(posedge sys_clk) disable iff (!rst_n)
    global_alarm_flag && !rd_sts |=> global_alarm_flag)
    else $error("global flag dropped without read");
  AST_GLOBAL_ALARM_FLAG_SET_RD: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rd_sts && any_alarm |=> global_alarm_flag)
    else $error("read cleared flag while alarm present");
  AST_GLOBAL_ALARM_FLAG_CLR: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rd_sts && !any_alarm |=> !global_alarm_flag)
    else $error("status read did not clear flag");

  // ****************************************
  // Filter length checks
  // ****************************************
  // One property per filter code, lengths from the code tables
  AST_CH_C0: assert property (@(posedge sys_clk) disable iff (!rst_n)
    input_alarm_filter_count == 3'h0 |-> ch_need == `ACS_CH_NEED_C0)
    else $error("input filter length wrong for code 0");
  AST_CH_FOUR: assert property (@(posedge sys_clk) disable iff (!rst_n)
    input_alarm_filter_count == `ACS_CH_CODE_FOUR |-> ch_need == `ACS_CH_NEED_C1)
    else $error("input filter length wrong");
  AST_CH_C2: assert property (@(posedge sys_clk) disable iff (!rst_n)
    input_alarm_filter_count == 3'h2 |-> ch_need == `ACS_CH_NEED_C2)
    else $error("input filter length wrong for code 2");
  AST_CH_C3: assert property (@(posedge sys_clk) disable iff (!rst_n)
    input_alarm_filter_count == 3'h3 |-> ch_need == `ACS_CH_NEED_C3)
    else $error("input filter length wrong for code 3");
  AST_CH_C4: assert property (@(posedge sys_clk) disable iff (!rst_n)
    input_alarm_filter_count == 3'h4 |-> ch_need == `ACS_CH_NEED_C4)
    else $error("input filter length wrong for code 4");
  AST_CH_C5: assert property (@(posedge sys_clk) disable iff (!rst_n)
    input_alarm_filter_count == 3'h5 |-> ch_need == `ACS_CH_NEED_C5)
    else $error("input filter length wrong for code 5");
  AST_CH_C6: assert property (@(posedge sys_clk) disable iff (!rst_n)
    input_alarm_filter_count == 3'h6 |-> ch_need == `ACS_CH_NEED_C6)
    else $error("input filter length wrong for code 6");
  AST_CH_C7: assert property (@(posedge sys_clk) disable iff (!rst_n)
    input_alarm_filter_count == `ACS_CH_CODE_MAX |-> ch_need == `ACS_CH_NEED_C7)
    else $error("input filter length wrong for code 7");
  AST_TP_C0: assert property (@(posedge sys_clk) disable iff (!rst_n)
    temp_alarm_filter_count == 2'h0 |-> tp_need == `ACS_TP_NEED_C0)
    else $error("temperature filter length wrong for code 0");
  AST_TP_C1: assert property (@(posedge sys_clk) disable iff (!rst_n)
    temp_alarm_filter_count == 2'h1 |-> tp_need == `ACS_TP_NEED_C1)
    else $error("temperature filter length wrong for code 1");
  AST_TP_LEN: assert property (@(posedge sys_clk) disable iff (!rst_n)
    temp_alarm_filter_count == 2'h2 |-> tp_need == `ACS_TP_NEED_C2)
    else $error("temperature filter length wrong");
  AST_TP_C3: assert property (@(posedge sys_clk) disable iff (!rst_n)
    temp_alarm_filter_count == 2'h3 |-> tp_need == `ACS_TP_NEED_C3)
    else $error("temperature filter length wrong for code 3");

  // ****************************************
  // Coverage of the main scenarios
  // ****************************************
  COV_STATUS_CLR: cover property (@(posedge sys_clk) disable iff (!rst_n)
    global_alarm_flag ##1 rd_sts ##1 !global_alarm_flag);
  COV_CFG_WR: cover property (@(posedge sys_clk) disable iff (!rst_n) wr_cfg);
  COV_CH_ALARM: cover property (@(posedge sys_clk) disable iff (!rst_n) |ch_alarm);
  COV_TEMP_ALARM: cover property (@(posedge sys_clk) disable iff (!rst_n) temp_alarm);
  COV_LONG_RUN: cover property (@(posedge sys_clk) disable iff (!rst_n)
    ch_alarm[0] && input_alarm_filter_count == `ACS_CH_CODE_MAX);
endmodule

// [verification/tb.sv]
// Self-checking testbench for the status and configuration register block.
// Assumes acs_params.svh, acs_pkg and the logic/ modules are compiled first.
`timescale 1ns/1ps
`include "acs_params.svh"
module tb
  import acs_pkg::*;
;
  // ****************************************
  // Stimulus and observation signals
  // ****************************************
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [6:0] reg_addr = 7'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata;
  logic [15:0] alarm_bits = 16'h0000;
  logic [3:0] ch_sample_valid = 4'h0;
  logic [3:0] ch_out_of_range = 4'h0;
  logic temp_sample_valid = 1'b0;
  logic temp_out_of_range = 1'b0;
  logic [3:0] ch_alarm;
  logic temp_alarm;
  logic [2:0] rate_shift;
  logic [1:0] conversion_rate_select;
  logic [2:0] input_alarm_filter_count;
  logic [1:0] temp_alarm_filter_count;
  int miscompares = 0;
  int tests_run = 0;
  int cycles = 0;

  acs_regs u_acs_regs (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .alarm_bits(alarm_bits), .ch_sample_valid(ch_sample_valid),
    .ch_out_of_range(ch_out_of_range), .temp_sample_valid(temp_sample_valid),
    .temp_out_of_range(temp_out_of_range), .ch_alarm(ch_alarm), .temp_alarm(temp_alarm),
    .rate_shift(rate_shift), .conversion_rate_select(conversion_rate_select),
    .input_alarm_filter_count(input_alarm_filter_count),
    .temp_alarm_filter_count(temp_alarm_filter_count));

  // ****************************************
  // Clock, hang guard and shared tasks
  // ****************************************
  always #2.5 sys_clk = ~sys_clk;

  // Cut a hang short well past the expected run
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares = miscompares + 1;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      miscompares = miscompares + 1;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Write one word; sample strobes are dropped meanwhile
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    {ch_sample_valid, temp_sample_valid} <= 5'h00;
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  // Read one word and compare it the cycle after the strobe
  task automatic rd(input logic [6:0] a, input logic [15:0] exp);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    check("reg_rdata", exp, reg_rdata);
  endtask

  // One sample on every channel, alarms judged in the same cycle
  task automatic smp(input logic oor, input logic [3:0] ech, input logic et);
    @(posedge sys_clk);
    ch_sample_valid <= 4'hF;
    ch_out_of_range <= {4{oor}};
    temp_sample_valid <= 1'b1;
    temp_out_of_range <= oor;
    #1;
    check("ch_alarm", {12'h000, ech}, {12'h000, ch_alarm});
    check("temp_alarm", {15'h0000, et}, {15'h0000, temp_alarm});
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset_and_reserved();
    rd(`ACS_ADDR_CFG1, 16'h0070);
    check("rate_select", 16'h0000, {14'h0000, conversion_rate_select});
    check("input_filter", 16'h0003, {13'h0000, input_alarm_filter_count});
    check("temp_filter", 16'h0002, {14'h0000, temp_alarm_filter_count});
    wr(`ACS_ADDR_CFG1, 16'hFFFF);
    rd(`ACS_ADDR_CFG1, 16'h03F8);
    rd(7'h00, 16'h0000);
  endtask

  task automatic t_rates();
    for (int c = 0; c < 4; c++) begin
      wr(`ACS_ADDR_CFG1, 16'(c) << 8);
      check("rate_shift", 16'(c), {13'h0000, rate_shift});
      check("rate_select", 16'(c), {14'h0000, conversion_rate_select});
      rd(`ACS_ADDR_CFG1, 16'(c) << 8);
    end
  endtask

  task automatic t_global_flag();
    @(posedge sys_clk) alarm_bits <= 16'h8000;
    @(posedge sys_clk) alarm_bits <= 16'h0000;
    rd(`ACS_ADDR_STATUS, 16'h0040);
    rd(`ACS_ADDR_STATUS, 16'h0000);
    @(posedge sys_clk) alarm_bits <= 16'h00BF;
    rd(`ACS_ADDR_STATUS, 16'h00C0);
    @(posedge sys_clk) alarm_bits <= 16'h0000;
    rd(`ACS_ADDR_STATUS, 16'h0040);
    rd(`ACS_ADDR_STATUS, 16'h0000);
  endtask

  // Every filter code: alarm exactly on the Nth unbroken bad sample
  task automatic t_filter_codes();
    int nc;
    int nt;
    for (int i = 0; i < 8; i++) begin
      nc = (i == 0) ? 1 : (1 << (i + 1));
      nt = 1 << (i % 4);
      wr(`ACS_ADDR_CFG1, (16'(i) << 5) | (16'(i % 4) << 3));
      check("input_filter", 16'(i), {13'h0000, input_alarm_filter_count});
      check("temp_filter", 16'(i % 4), {14'h0000, temp_alarm_filter_count});
      for (int k = 1; k <= ((nc > nt) ? nc : nt); k++) begin
        smp(1'b1, (k == nc) ? 4'hF : 4'h0, k == nt);
      end
      smp(1'b0, 4'h0, 1'b0);
    end
  endtask

  // A good sample mid-run restarts the count
  task automatic t_run_restart();
    wr(`ACS_ADDR_CFG1, 16'h0028);
    for (int k = 0; k < 8; k++) begin
      smp(k != 3, (k == 7) ? 4'hF : 4'h0, k == 1 || k == 5);
    end
    @(posedge sys_clk);
    {ch_sample_valid, temp_sample_valid} <= 5'h00;
  endtask

  initial begin
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_reset_and_reserved();
    t_rates();
    t_global_flag();
    t_filter_codes();
    t_run_restart();
    give_verdict();
  end
endmodule
